// ### verilog/refclk_output_generator.v
// top of the reference clock output generator: registers, control, pin
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "refclk_defines.vh"

module refclk_output_generator #(
    parameter ADDR_W = 4,  // register address width
    parameter DIV_W = 15   // divisor width
) (
    input wire i_sys_clk,                 // 40 MHz system clock
    input wire i_sys_rst,                 // synchronous reset, high
    input wire [ADDR_W-1:0] i_addr,       // register word address
    input wire [15:0] i_wdata,            // write data
    input wire i_wr,                      // write strobe
    input wire i_rd,                      // read strobe
    output reg [15:0] o_rdata,            // read data, cycle after strobe
    input wire i_idle_mode,               // device in Idle
    input wire i_sleep_mode,              // device in Sleep
    input wire [2:0] i_current_oscillator_select, // system oscillator
    input wire i_pll_input_source_select, // pll feed configuration bit
    input wire i_osc_clk,                 // oscillator clock
    input wire i_periph_clk,              // peripheral clock
    input wire i_primary_oscillator,      // primary oscillator
    input wire i_fast_rc_clock,           // fast rc
    input wire i_low_power_rc_clock,      // low power rc
    input wire i_secondary_oscillator,    // secondary oscillator
    input wire i_pll_frc_clk,             // pll fed from fast rc
    input wire i_pll_primary_oscillator_clk,            // pll fed from primary
    input wire i_reference_input_pin,     // reference input pin
    output reg o_reference_clock_pin,     // reference clock pin
    output reg o_refclk,                  // internal reference clock
    output reg o_refclk_active_flag,      // mirror of active flag
    output reg o_divider_switch_request   // mirror of switch bit
);

    // ==========================================================
    // control state
    reg refclk_enable_ff;
    reg refclk_idle_stop_ff;
    reg refclk_pin_drive_ff;
    reg refclk_sleep_run_ff;
    reg divider_switch_request_ff;
    reg refclk_active_flag_ff;
    reg [3:0] refclk_source_select_ff;
    reg [DIV_W-1:0] refclk_half_period_divisor_ff;
    reg [DIV_W-1:0] div_in_effect_ff;
    reg pin_gate_ff;
    reg [15:0] nxt_rdata;
    reg run_ff;

    wire wr_low;
    wire wr_div;
    wire src_lvl;
    wire src_rise;
    wire div_clk;
    wire div_gate;
    wire period_end;
    wire nxt_run;
    wire apply_div;
    wire [15:0] ctrl_low_view;
    wire [15:0] divider_view;

    // ==========================================================
    // register decode
    assign wr_low = i_wr && (i_addr == `REFCLK_ADDR_CTRL_LOW);
    assign wr_div = i_wr && (i_addr == `REFCLK_ADDR_DIVIDER);

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            refclk_enable_ff <= 1'b0;
            refclk_idle_stop_ff <= 1'b0;
            refclk_pin_drive_ff <= 1'b0;
            refclk_sleep_run_ff <= 1'b0;
            refclk_source_select_ff <= 4'h0;
        end else if (wr_low) begin
            refclk_enable_ff <= i_wdata[`REFCLK_BIT_ENABLE];
            refclk_idle_stop_ff <= i_wdata[`REFCLK_BIT_IDLE_STOP];
            refclk_pin_drive_ff <= i_wdata[`REFCLK_BIT_PIN_DRIVE];
            refclk_sleep_run_ff <= i_wdata[`REFCLK_BIT_SLEEP_RUN];
            refclk_source_select_ff <= i_wdata[`REFCLK_SEL_MSB:`REFCLK_SEL_LSB];
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            refclk_half_period_divisor_ff <= {DIV_W{1'b0}};
        end else if (wr_div) begin
            refclk_half_period_divisor_ff <= i_wdata[DIV_W-1:0];
        end
    end

    // ==========================================================
    // divider switch handshake
    // new divisor takes effect on a period boundary, or at once when idle
    assign apply_div = divider_switch_request_ff && (period_end || !div_gate);

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            divider_switch_request_ff <= 1'b0;
            div_in_effect_ff <= {DIV_W{1'b0}};
        end else begin
            if (apply_div) begin
                div_in_effect_ff <= refclk_half_period_divisor_ff;
            end
            // a software set beats the hardware clear
            if (wr_low && i_wdata[`REFCLK_BIT_SWITCH]) begin
                divider_switch_request_ff <= 1'b1;
            end else if (apply_div) begin
                divider_switch_request_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // power mode gating
    assign nxt_run = refclk_enable_ff
        && !(i_idle_mode && refclk_idle_stop_ff)
        && !(i_sleep_mode && !refclk_sleep_run_ff);

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            run_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
        end
    end

    // ==========================================================
    // active flag
    // stays set until the divider has wound down to a low output
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            refclk_active_flag_ff <= 1'b0;
        end else begin
            refclk_active_flag_ff <= refclk_enable_ff | div_gate | div_clk;
        end
    end

    // ==========================================================
    // source selection and division
    refclk_source_mux u_mux (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_sel(refclk_source_select_ff),
        .i_cur_osc(i_current_oscillator_select),
        .i_pll_input_source_select(i_pll_input_source_select),
        .i_osc_clk(i_osc_clk),
        .i_periph_clk(i_periph_clk),
        .i_primary_oscillator(i_primary_oscillator),
        .i_fast_rc_clock(i_fast_rc_clock),
        .i_low_power_rc_clock(i_low_power_rc_clock),
        .i_secondary_oscillator(i_secondary_oscillator),
        .i_pll_frc_clk(i_pll_frc_clk),
        .i_pll_primary_oscillator_clk(i_pll_primary_oscillator_clk),
        .i_reference_input_pin(i_reference_input_pin),
        .o_src_lvl(src_lvl),
        .o_src_rise(src_rise)
    );

    refclk_divider #(
        .DIV_W(DIV_W)
    ) u_div (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_src_lvl(src_lvl),
        .i_src_rise(src_rise),
        .i_div(div_in_effect_ff),
        .i_run(run_ff),
        .o_clk(div_clk),
        .o_gate(div_gate),
        .o_period_end(period_end)
    );

    // ==========================================================
    // pin drive
    // drive gate moves only while the clock is low, so no runt pulses
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pin_gate_ff <= 1'b0;
        end else if (!div_clk) begin
            pin_gate_ff <= refclk_pin_drive_ff & refclk_enable_ff;
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_reference_clock_pin <= 1'b0;
            o_refclk <= 1'b0;
            o_refclk_active_flag <= 1'b0;
            o_divider_switch_request <= 1'b0;
        end else begin
            o_reference_clock_pin <= pin_gate_ff & div_clk;
            o_refclk <= div_clk;
            o_refclk_active_flag <= refclk_active_flag_ff;
            o_divider_switch_request <= divider_switch_request_ff;
        end
    end

    // ==========================================================
    // read back
    assign ctrl_low_view = {
        refclk_enable_ff,
        1'b0,
        refclk_idle_stop_ff,
        refclk_pin_drive_ff,
        refclk_sleep_run_ff,
        1'b0,
        divider_switch_request_ff,
        refclk_active_flag_ff,
        4'h0,
        refclk_source_select_ff
    };
    assign divider_view = {1'b0, refclk_half_period_divisor_ff};

    always @* begin
        nxt_rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `REFCLK_ADDR_CTRL_LOW: nxt_rdata = ctrl_low_view;
                `REFCLK_ADDR_DIVIDER: nxt_rdata = divider_view;
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= nxt_rdata;
        end
    end

endmodule

// ### verilog/refclk_defines.vh
// constants for the reference clock output generator
`ifndef REFCLK_DEFINES_VH
`define REFCLK_DEFINES_VH

// ==========================================================
// register word addresses
`define REFCLK_ADDR_CTRL_LOW 4'h0
`define REFCLK_ADDR_DIVIDER 4'h1

// ==========================================================
// control low field positions
`define REFCLK_BIT_ENABLE 15
`define REFCLK_BIT_IDLE_STOP 13
`define REFCLK_BIT_PIN_DRIVE 12
`define REFCLK_BIT_SLEEP_RUN 11
`define REFCLK_BIT_SWITCH 9
`define REFCLK_BIT_ACTIVE 8
`define REFCLK_SEL_MSB 3
`define REFCLK_SEL_LSB 0
`define REFCLK_DIV_MSB 14

// ==========================================================
// reset values
`define REFCLK_CTRL_LOW_RST 16'h0000
`define REFCLK_DIVIDER_RST 16'h0000

// ==========================================================
// source select codes
`define REFCLK_SRC_OSC 4'h0
`define REFCLK_SRC_PERIPH 4'h1
`define REFCLK_SRC_PRIMARY 4'h2
`define REFCLK_SRC_FAST_RC 4'h3
`define REFCLK_SRC_LOW_POWER_RC 4'h4
`define REFCLK_SRC_SECONDARY 4'h5
`define REFCLK_SRC_PLL 4'h6
`define REFCLK_SRC_INPUT_PIN 4'h8

// ==========================================================
// system oscillator selections that own the pll
`define REFCLK_COSC_PLL_A 3'h1
`define REFCLK_COSC_PLL_B 3'h3

`endif

// ### verilog/refclk_source_mux.v
// source selection and sampling of the chosen reference source
`timescale 1ns/1ps
`include "refclk_defines.vh"

module refclk_source_mux (
    input wire i_sys_clk,                 // system clock
    input wire i_sys_rst,                 // synchronous reset, high
    input wire [3:0] i_sel,               // source select code
    input wire [2:0] i_cur_osc,           // current oscillator select
    input wire i_pll_input_source_select, // 0 fast rc fed pll, 1 primary fed pll
    input wire i_osc_clk,                 // oscillator (system) clock level
    input wire i_periph_clk,              // peripheral clock level
    input wire i_primary_oscillator,      // primary oscillator level
    input wire i_fast_rc_clock,           // fast rc level
    input wire i_low_power_rc_clock,      // low power rc level
    input wire i_secondary_oscillator,    // secondary oscillator level
    input wire i_pll_frc_clk,             // pll output, fast rc input
    input wire i_pll_primary_oscillator_clk,            // pll output, primary input
    input wire i_reference_input_pin,     // reference input pin level
    output wire o_src_lvl,                // sampled source level
    output wire o_src_rise                // one-cycle pulse on source rise
);

    reg src_lvl_ff;
    reg src_prev_ff;
    reg pll_lvl;
    reg nxt_src_lvl;

    // pll unavailable while it drives the system clock
    always @* begin
        pll_lvl = 1'b0;
        if ((i_cur_osc != `REFCLK_COSC_PLL_A) && (i_cur_osc != `REFCLK_COSC_PLL_B)) begin
            pll_lvl = i_pll_input_source_select ? i_pll_primary_oscillator_clk : i_pll_frc_clk;
        end
    end

    always @* begin
        case (i_sel)
            `REFCLK_SRC_OSC: nxt_src_lvl = i_osc_clk;
            `REFCLK_SRC_PERIPH: nxt_src_lvl = i_periph_clk;
            `REFCLK_SRC_PRIMARY: nxt_src_lvl = i_primary_oscillator;
            `REFCLK_SRC_FAST_RC: nxt_src_lvl = i_fast_rc_clock;
            `REFCLK_SRC_LOW_POWER_RC: nxt_src_lvl = i_low_power_rc_clock;
            `REFCLK_SRC_SECONDARY: nxt_src_lvl = i_secondary_oscillator;
            `REFCLK_SRC_PLL: nxt_src_lvl = pll_lvl;
            `REFCLK_SRC_INPUT_PIN: nxt_src_lvl = i_reference_input_pin;
            default: nxt_src_lvl = 1'b0;
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            src_lvl_ff <= 1'b0;
            src_prev_ff <= 1'b0;
        end else begin
            src_lvl_ff <= nxt_src_lvl;
            src_prev_ff <= src_lvl_ff;
        end
    end

    assign o_src_lvl = src_lvl_ff;
    assign o_src_rise = src_lvl_ff & ~src_prev_ff;

endmodule

// ### verilog/refclk_divider.v
// even divider with bypass and glitch-free start and stop
`timescale 1ns/1ps

module refclk_divider #(
    parameter DIV_W = 15 // divisor width
) (
    input wire i_sys_clk,           // system clock
    input wire i_sys_rst,           // synchronous reset, high
    input wire i_src_lvl,           // sampled source level
    input wire i_src_rise,          // source rising pulse
    input wire [DIV_W-1:0] i_div,   // half period divisor in effect
    input wire i_run,               // request to run
    output wire o_clk,              // reference clock level
    output wire o_gate,             // divider running
    output wire o_period_end        // pulse after each falling output edge
);

    reg out_ff;
    reg gate_ff;
    reg end_ff;
    reg [DIV_W-1:0] cnt_ff;
    wire bypass;
    wire [DIV_W-1:0] last;

    assign bypass = (i_div == {DIV_W{1'b0}});
    assign last = i_div - {{(DIV_W-1){1'b0}}, 1'b1};

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            out_ff <= 1'b0;
            gate_ff <= 1'b0;
            end_ff <= 1'b0;
            cnt_ff <= {DIV_W{1'b0}};
        end else begin
            end_ff <= 1'b0;
            // gate only moves while output is low, and in bypass only while source is low too
            if (!out_ff && !(bypass && i_src_lvl)) begin
                gate_ff <= i_run;
            end
            if (bypass) begin
                cnt_ff <= {DIV_W{1'b0}};
                out_ff <= gate_ff & i_src_lvl;
                end_ff <= out_ff & ~(gate_ff & i_src_lvl);
            end else if (gate_ff && i_src_rise) begin
                if (cnt_ff >= last) begin
                    cnt_ff <= {DIV_W{1'b0}};
                    out_ff <= ~out_ff;
                    end_ff <= out_ff;
                end else begin
                    cnt_ff <= cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
                end
            end else if (!gate_ff) begin
                cnt_ff <= {DIV_W{1'b0}};
            end
        end
    end

    assign o_clk = out_ff;
    assign o_gate = gate_ff;
    assign o_period_end = end_ff;

endmodule

// ### testbench/refclk_output_generator_props.sv
// assertion checker for the reference clock output generator
`timescale 1ns/1ps

module refclk_output_generator_props #(
    parameter ADDR_W = 4,
    parameter DIV_W = 15
) (
    input wire i_sys_clk,                // system clock
    input wire i_sys_rst,                // synchronous reset
    input wire [ADDR_W-1:0] i_addr,      // register address
    input wire [15:0] i_wdata,           // write data
    input wire i_wr,                     // write strobe
    input wire i_rd,                     // read strobe
    input wire [15:0] o_rdata,           // read data
    input wire o_reference_clock_pin,    // pin level
    input wire o_refclk,                 // internal clock
    input wire o_refclk_active_flag,     // active mirror
    input wire o_divider_switch_request  // switch mirror
);
    reg en_ff;
    reg drv_ff;
    wire ctrl_wr = i_wr && (i_addr == 0);

    // ==========================================
    // shadow of enable and pin drive
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            en_ff <= 1'b0;
            drv_ff <= 1'b0;
        end else if (ctrl_wr) begin
            en_ff <= i_wdata[15];
            drv_ff <= i_wdata[12];
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    // ==========================================
    // properties
    sequence s_switch_write;
        ctrl_wr && i_wdata[9];
    endsequence
    sequence s_flag_drops;
        ##[1:300] !o_refclk_active_flag;
    endsequence

    AST_READ_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    AST_UNIMPL_ZERO: assert property ($past(i_rd) && $past(i_addr) == 0 |->
        (o_rdata & 16'h44f0) == 16'h0000) else $error("unused control bit reads one");
    AST_DIV_TOP_ZERO: assert property ($past(i_rd) && $past(i_addr) == 1 |->
        !o_rdata[15]) else $error("divider bit 15 reads one");
    AST_UNMAPPED: assert property ($past(i_rd) && $past(i_addr) > 1 |-> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_PIN_IS_CLOCK: assert property (o_reference_clock_pin |->
        o_refclk || $past(o_refclk)) else $error("pin high without clock");
    AST_PIN_DRIVE_OFF: assert property (!drv_ff && !$past(drv_ff) &&
        !$past(o_reference_clock_pin) |-> !o_reference_clock_pin)
        else $error("pin driven while off");
    AST_ACTIVE_RISE: assert property ($rose(en_ff) |-> ##[1:6] o_refclk_active_flag)
        else $error("active flag late after enable");
    AST_ACTIVE_FALL: assert property ($fell(en_ff) |-> s_flag_drops)
        else $error("active flag stuck after disable");
    AST_SWITCH_SET: assert property (s_switch_write |-> ##2 o_divider_switch_request)
        else $error("switch bit not set by write");
    AST_SWITCH_CLEARS: assert property ($rose(o_divider_switch_request) |->
        ##[1:400] !o_divider_switch_request) else $error("switch bit never clears");
    AST_OFF_LOW: assert property (!en_ff && !o_refclk_active_flag |->
        !o_reference_clock_pin) else $error("pin high while disabled");
endmodule

// ### testbench/refclk_far_side.sv
// far side model: free running sources and pin period meter
`timescale 1ns/1ps

module refclk_far_side (
    input wire i_sys_clk,         // system clock
    input wire i_pin,             // reference clock pin
    output reg [8:0] o_src,       // source k half period k+2 cycles
    output integer o_period,      // cycles between pin rises
    output integer o_edges        // pin rise count
);
    integer cnt [0:8];
    integer since;
    integer k;
    reg pin_q;

    initial begin
        o_src = 9'h000;
        o_period = 0;
        o_edges = 0;
        since = 0;
        pin_q = 1'b0;
        for (k = 0; k < 9; k = k + 1) begin
            cnt[k] = 0;
        end
    end

    // sources never stop, sleep included
    always @(posedge i_sys_clk) begin
        for (k = 0; k < 9; k = k + 1) begin
            cnt[k] = cnt[k] + 1;
            if (cnt[k] >= k + 2) begin
                cnt[k] = 0;
                o_src[k] <= ~o_src[k];
            end
        end
        since = since + 1;
        if (i_pin && !pin_q) begin
            o_period <= since;
            o_edges <= o_edges + 1;
            since = 0;
        end
        pin_q <= i_pin;
    end
endmodule

// ### testbench/refclk_output_generator_test.sv
// self-checking bench for the reference clock output generator
`timescale 1ns/1ps

module refclk_output_generator_test;
    reg i_sys_clk = 1'b0;
    reg i_sys_rst = 1'b1;
    reg [3:0] i_addr = 4'h0;
    reg [15:0] i_wdata = 16'h0000;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg i_idle_mode = 1'b0;
    reg i_sleep_mode = 1'b0;
    reg [2:0] i_current_oscillator_select = 3'h2;
    reg i_pll_input_source_select = 1'b0;
    wire [15:0] rdata;
    wire pin;
    wire refclk;
    wire [8:0] src;
    wire [31:0] period;
    wire [31:0] edges;
    integer num_errors = 0;
    integer checks_done = 0;
    integer cycles = 0;
    integer ref_rises = 0;
    integer i, n, idx, e, r0;
    reg [31:0] seed = 32'he9b1_b2fc;
    reg [31:0] r;
    reg [15:0] mreg [0:3] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [3:0] codes [0:8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h6, 4'h8};
    logic [3:0] bad_sel [0:3] = '{4'h7, 4'hf, 4'h6, 4'h6};
    logic [2:0] bad_osc [0:3] = '{3'h0, 3'h2, 3'h1, 3'h3};
    logic [15:0] mode_bits [0:3] = '{16'h2000, 16'h0000, 16'h0800, 16'h0000};
    logic [2:0] mode_ctl [0:3] = '{3'b010, 3'b011, 3'b101, 3'b100};

    refclk_output_generator #(.ADDR_W(4), .DIV_W(15)) dut (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_idle_mode(i_idle_mode),
        .i_sleep_mode(i_sleep_mode),
        .i_current_oscillator_select(i_current_oscillator_select),
        .i_pll_input_source_select(i_pll_input_source_select), .i_osc_clk(src[0]),
        .i_periph_clk(src[1]), .i_primary_oscillator(src[2]), .i_fast_rc_clock(src[3]),
        .i_low_power_rc_clock(src[4]), .i_secondary_oscillator(src[5]),
        .i_pll_frc_clk(src[6]), .i_pll_primary_oscillator_clk(src[7]), .i_reference_input_pin(src[8]),
        .o_reference_clock_pin(pin), .o_refclk(refclk), .o_refclk_active_flag(),
        .o_divider_switch_request());

    refclk_far_side far (.i_sys_clk(i_sys_clk), .i_pin(pin), .o_src(src),
        .o_period(period), .o_edges(edges));

    initial begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge refclk) ref_rises++;

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        mreg[a[1:0]] = d & ((a == 0) ? 16'hba0f : (a == 1) ? 16'h7fff : 16'h0000);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(posedge i_sys_clk);
        d = rdata;
    endtask

    task automatic rchk(input logic [3:0] a);
        logic [15:0] d;
        rd(a, d);
        chk(d, mreg[a[1:0]]);
    endtask

    task automatic wait_ctrl(input integer b, input logic v);
        logic [15:0] d;
        integer k = 0;
        rd(4'h0, d);
        while (d[b] !== v && k < 300) begin
            rd(4'h0, d);
            k++;
        end
        chk(d[b], v);
    endtask

    task automatic meas(input integer exp);
        integer e0 = edges;
        integer k = 0;
        while (edges < e0 + 3 && k < 3000) begin
            @(posedge i_sys_clk);
            k++;
        end
        chk(edges >= e0 + 3, 1);
        chk(period, exp);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        for (i = 0; i < 3; i++) rchk(i[3:0]);
        wr(4'h0, 16'h7df7);
        rchk(4'h0);
        wr(4'h1, 16'hffff);
        rchk(4'h1);
        r = rnd();
        wr(4'h1, r[15:0]);
        rchk(4'h1);
        wr(4'h2, 16'hffff);
        rchk(4'h2);
        wr(4'h0, 16'h0000);
        $display("test registers done");
        for (i = 0; i < 9; i++) begin
            n = rnd() % 4;
            i_pll_input_source_select <= i[0];
            idx = (codes[i] == 4'h6) ? 6 + i[0] : codes[i];
            wr(4'h1, n[15:0]);
            wr(4'h0, {12'h920, codes[i]});
            wait_ctrl(9, 1'b0);
            meas((n == 0) ? 2 * (idx + 2) : 4 * n * (idx + 2));
            wait_ctrl(8, 1'b1);
            wr(4'h0, 16'h0000);
            wait_ctrl(8, 1'b0);
        end
        $display("test sources done");
        for (i = 0; i < 4; i++) begin
            i_current_oscillator_select <= bad_osc[i];
            wr(4'h0, {12'h900, bad_sel[i]});
            e = edges;
            repeat (200) @(posedge i_sys_clk);
            chk(edges - e, 0);
            wr(4'h0, 16'h0000);
            wait_ctrl(8, 1'b0);
        end
        i_current_oscillator_select <= 3'h0;
        $display("test refused sources done");
        wr(4'h1, 16'h0001);
        wr(4'h0, 16'h8201);
        wait_ctrl(9, 1'b0);
        e = edges;
        r0 = ref_rises;
        repeat (200) @(posedge i_sys_clk);
        chk(edges - e, 0);
        chk(ref_rises > r0, 1);
        $display("test pin drive done");
        for (i = 0; i < 4; i++) begin
            wr(4'h0, 16'h9001 | mode_bits[i]);
            i_idle_mode <= mode_ctl[i][1];
            i_sleep_mode <= mode_ctl[i][2];
            repeat (60) @(posedge i_sys_clk);
            e = edges;
            repeat (200) @(posedge i_sys_clk);
            chk(edges > e, mode_ctl[i][0]);
            i_idle_mode <= 1'b0;
            i_sleep_mode <= 1'b0;
        end
        $display("test power modes done");
        tally_and_finish();
    end
endmodule

bind refclk_output_generator refclk_output_generator_props #(.ADDR_W(ADDR_W), .DIV_W(DIV_W))
    u_props (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_reference_clock_pin(o_reference_clock_pin), .o_refclk(o_refclk),
    .o_refclk_active_flag(o_refclk_active_flag),
    .o_divider_switch_request(o_divider_switch_request));
